// file: sense_ctrl.sv
// Controller that drives the switch-sense interface select pins
`timescale 1ns/1ps
`default_nettype none
`include "sense_ctrl_consts.svh"
// Functional notes
// - Select pin 0 is the leftmost code bit; channel 1 is 001b.
// - Drive channel code with enable low, then raise enable and hold.
// - Start with all select and enable pins low.
// - Release the shared line by returning select pins to 000b.
module sense_ctrl
	import sense_ctrl_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_start,
	input wire logic [2:0] i_supply_channel,
	input wire logic i_current_mode,
	input wire logic i_measure_valid,
	input wire logic [2:0] i_measure_channel,
	input wire logic i_stop,
	output logic o_busy,
	output logic o_supplying,
	output logic o_sel0,
	output logic o_sel1,
	output logic o_sel2,
	output logic o_enable,
	output logic o_meas_mode_select
);
	ctrl_state_type state_reg, state_next;
	logic [2:0] sel_reg, sel_next;
	logic en_reg, en_next;
	logic mode_reg, mode_next;
	logic [`CNT_W-1:0] cnt_reg, cnt_next;

	// State decoding
	wire in_idle = (state_reg == ST_IDLE);
	wire in_setup = (state_reg == ST_SETUP);
	wire in_supply = (state_reg == ST_SUPPLY);
	wire in_release = (state_reg == ST_RELEASE);

	// Request qualification
	wire chan_low_ok = (i_supply_channel >= `SEL_CH_MIN);
	wire chan_high_ok = (i_supply_channel <= `SEL_CH_MAX);
	wire start_ok = i_start && chan_low_ok && chan_high_ok;
	wire measure_ok = i_measure_valid && !mode_reg;
	wire setup_done = (cnt_reg == `CNT_W'(`SETUP_CYCLES - 1));

	// Next state and pin values
	always_comb
	begin
		state_next = state_reg;
		sel_next = sel_reg;
		en_next = en_reg;
		mode_next = mode_reg;
		cnt_next = cnt_reg;
		unique case (state_reg)
			ST_IDLE:
			begin
				if (start_ok)
				begin
					sel_next = i_supply_channel;
					mode_next = i_current_mode;
					cnt_next = '0;
					state_next = ST_SETUP;
				end
			end
			ST_SETUP:
			begin
				cnt_next = cnt_reg + `CNT_W'(1);
				if (setup_done)
				begin
					en_next = 1'b1;
					state_next = ST_SUPPLY;
				end
			end
			ST_SUPPLY:
			begin
				if (i_stop)
				begin
					en_next = 1'b0;
					state_next = ST_RELEASE;
				end
				else if (measure_ok)
					sel_next = i_measure_channel;
			end
			ST_RELEASE:
			begin
				sel_next = `SEL_HIGHZ;
				state_next = ST_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
			state_reg <= ST_IDLE;
		else
			state_reg <= state_next;
	end

	// Select pin register
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
			sel_reg <= `SEL_HIGHZ;
		else
			sel_reg <= sel_next;
	end

	// Enable pin register
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
			en_reg <= 1'b0;
		else
			en_reg <= en_next;
	end

	// Mode pin register
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
			mode_reg <= 1'b0;
		else
			mode_reg <= mode_next;
	end

	// Setup counter
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
			cnt_reg <= '0;
		else
			cnt_reg <= cnt_next;
	end

	// Pin mapping
	assign o_sel0 = sel_reg[2];
	assign o_sel1 = sel_reg[1];
	assign o_sel2 = sel_reg[0];
	assign o_enable = en_reg;
	assign o_meas_mode_select = mode_reg;

	// Status outputs
	assign o_busy = !in_idle;
	assign o_supplying = in_supply;

	// Assertions
	enable_after_setup_a: assert property (@(posedge i_clk) disable iff (i_reset)
		$rose(en_reg) |-> ($past(sel_reg) == sel_reg) && $past(state_reg) == ST_SETUP)
		else $error("enable rose without stable setup");
	reset_idle_a: assert property (@(posedge i_clk) $past(i_reset) |-> !en_reg && sel_reg == `SEL_HIGHZ)
		else $error("pins not low after reset");
	release_zero_a: assert property (@(posedge i_clk) disable iff (i_reset)
		$fell(en_reg) |=> sel_reg == `SEL_HIGHZ && !en_reg)
		else $error("select not returned to zero");
	sel_idle_zero_a: assert property (@(posedge i_clk) disable iff (i_reset)
		state_reg == ST_IDLE |-> sel_reg == `SEL_HIGHZ && !en_reg)
		else $error("idle with pins driven");
	cm_sel_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
		en_reg && $past(en_reg) && mode_reg |-> $stable(sel_reg))
		else $error("select moved in current mode");
	bit_order_a: assert property (@(posedge i_clk) disable iff (i_reset)
		sel_reg == `SEL_CH_MIN |-> !o_sel0 && !o_sel1 && o_sel2)
		else $error("bit order wrong");
	mode_stable_a: assert property (@(posedge i_clk) disable iff (i_reset)
		en_reg |-> $stable(mode_reg))
		else $error("mode changed while supplying");
	setup_len_a: assert property (@(posedge i_clk) disable iff (i_reset)
		state_reg == ST_IDLE ##1 state_reg == ST_SETUP |-> !en_reg [*2] ##1 en_reg)
		else $error("setup length wrong");
	start_take_a: assert property (@(posedge i_clk) disable iff (i_reset)
		in_idle && start_ok |=> in_setup && sel_reg == $past(i_supply_channel) && mode_reg == $past(i_current_mode))
		else $error("start request not taken");
	start_refuse_a: assert property (@(posedge i_clk) disable iff (i_reset)
		in_idle && !start_ok |=> in_idle && !en_reg)
		else $error("refused start left idle");
	setup_clear_a: assert property (@(posedge i_clk) disable iff (i_reset)
		in_idle && start_ok |=> cnt_reg == '0)
		else $error("setup count not cleared");
	setup_sel_a: assert property (@(posedge i_clk) disable iff (i_reset)
		in_setup |-> !en_reg && sel_reg >= `SEL_CH_MIN && sel_reg <= `SEL_CH_MAX)
		else $error("setup without channel code");
	en_supply_a: assert property (@(posedge i_clk) disable iff (i_reset)
		en_reg |-> in_supply)
		else $error("enable high outside supply");
	supply_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
		in_supply && !i_stop |=> en_reg)
		else $error("enable dropped without stop");
	stop_drop_a: assert property (@(posedge i_clk) disable iff (i_reset)
		in_supply && i_stop |=> in_release && !en_reg)
		else $error("stop did not drop enable");
	release_idle_a: assert property (@(posedge i_clk) disable iff (i_reset)
		in_release |=> in_idle && sel_reg == `SEL_HIGHZ)
		else $error("release did not clear select");
	vm_measure_a: assert property (@(posedge i_clk) disable iff (i_reset)
		in_supply && !i_stop && i_measure_valid && !mode_reg |=> sel_reg == $past(i_measure_channel))
		else $error("measure channel not applied");

	// Covers
	supply_c: cover property (@(posedge i_clk) disable iff (i_reset) $rose(en_reg));
	cross_c: cover property (@(posedge i_clk) disable iff (i_reset) en_reg && !mode_reg && $changed(sel_reg));
	release_c: cover property (@(posedge i_clk) disable iff (i_reset) $fell(en_reg) ##1 state_reg == ST_IDLE);
	cm_supply_c: cover property (@(posedge i_clk) disable iff (i_reset) en_reg && mode_reg);
	refuse_c: cover property (@(posedge i_clk) disable iff (i_reset) in_idle && i_start && !start_ok);
endmodule
`default_nettype wire

// file: sense_ctrl_consts.svh
// Constants for the sense channel controller
`ifndef SENSE_CTRL_CONSTS_SVH
`define SENSE_CTRL_CONSTS_SVH
`define SEL_HIGHZ 3'h0
`define SEL_OVERTEMP 3'h7
`define SEL_CH_MIN 3'h1
`define SEL_CH_MAX 3'h6
`define SETUP_TIME_NS 100
`define CLK_PERIOD_NS 50
`define SETUP_CYCLES ((`SETUP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W 4
`endif

// file: sense_ctrl_pkg.sv
// Types for the sense channel controller
package sense_ctrl_pkg;
	typedef enum logic [1:0]
	{
		ST_IDLE = 2'h0,
		ST_SETUP = 2'h1,
		ST_SUPPLY = 2'h3,
		ST_RELEASE = 2'h2
	} ctrl_state_type;
endpackage

// file: sense_ctrl_tb.sv
// Testbench for the sense channel controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin error_cnt++; $display("mismatch %s exp %h got %h", n, e, s); end end
module sense_ctrl_tb;
	logic i_clk = 0, i_reset = 1, i_start = 0, i_current_mode = 0, i_measure_valid = 0, i_stop = 0;
	logic [2:0] i_supply_channel = 3'h0, i_measure_channel = 3'h0, held, sup;
	logic o_busy, o_supplying, o_sel0, o_sel1, o_sel2, o_enable, o_meas_mode_select;
	logic thermal = 1, mz, mot, mcur;
	logic [2:0] mch;
	logic [3:0] mdiv;
	int error_cnt = 0, n_compared = 0, cyc = 0, k, c;
	wire logic [2:0] live = {o_sel0, o_sel1, o_sel2};
	sense_ctrl i_dut (.i_clk(i_clk), .i_reset(i_reset), .i_start(i_start), .i_supply_channel(i_supply_channel),
		.i_current_mode(i_current_mode), .i_measure_valid(i_measure_valid), .i_measure_channel(i_measure_channel),
		.i_stop(i_stop), .o_busy(o_busy), .o_supplying(o_supplying), .o_sel0(o_sel0), .o_sel1(o_sel1),
		.o_sel2(o_sel2), .o_enable(o_enable), .o_meas_mode_select(o_meas_mode_select));
	sense_dev_model i_dev (.i_sel0(o_sel0), .i_sel1(o_sel1), .i_sel2(o_sel2), .i_enable(o_enable),
		.i_meas_mode_select(o_meas_mode_select), .i_thermal(thermal), .o_held(held), .o_sup(sup),
		.o_meas_z(mz), .o_meas_ot(mot), .o_meas_ch(mch), .o_meas_current(mcur), .o_meas_div(mdiv));
	initial
		forever #25 i_clk = ~i_clk;
	always @(posedge i_clk)
		if (++cyc == 3000)
		begin
			error_cnt++;
			complete_run();
		end
	task complete_run;
		$display("errors %0d compared %0d", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task step;
		@(posedge i_clk);
		#1;
	endtask
	task run(input logic [2:0] ch, input logic cm);
		step();
		i_start = 1;
		i_supply_channel = ch;
		i_current_mode = cm;
		step();
		i_start = 0;
		for (k = 0; k < 4 && live !== ch; k++) step();
		`CHK("held", ch, held)
		`CHK("sup_low", 3'h0, sup)
		`CHK("mode", cm, o_meas_mode_select)
		for (k = 0; k < 6 && o_enable !== 1'b1; k++) step();
		`CHK("sup", ch, sup)
		`CHK("supplying", 1'b1, o_supplying)
		i_measure_valid = 1;
		i_measure_channel = 3'h7;
		step();
		i_measure_valid = 0;
		step();
		`CHK("live", cm ? ch : 3'h7, live)
		`CHK("held_frozen", ch, held)
		`CHK("meas_ch", cm ? ch : 3'h7, mch)
		`CHK("meas_cur", cm, mcur)
		`CHK("meas_div", cm ? 4'ha : 4'h2, mdiv)
		i_stop = 1;
		step();
		i_stop = 0;
		for (k = 0; k < 4 && o_enable !== 1'b0; k++) step();
		`CHK("sup_off", 3'h0, sup)
		`CHK("ovt", !cm, mot)
		for (k = 0; k < 4 && o_busy !== 1'b0; k++) step();
		`CHK("released", 3'h0, live)
		`CHK("meas_z", 1'b1, mz)
		`CHK("ot_off", 1'b0, mot)
		`CHK("z_dom", 1'b0, mcur)
	endtask
	task refuse(input logic [2:0] ch);
		step();
		i_start = 1;
		i_supply_channel = ch;
		step();
		i_start = 0;
		step();
		`CHK("refused", 1'b0, o_busy)
	endtask
	initial
	begin
		repeat (10) step();
		`CHK("reset_pins", 4'h0, {live, o_enable})
		i_reset = 0;
		for (c = 1; c < 7; c++) run(c[2:0], c[0]);
		refuse(3'h7);
		refuse(3'h0);
		step();
		i_start = 1;
		i_supply_channel = 3'h3;
		i_current_mode = 0;
		step();
		i_start = 0;
		for (k = 0; k < 6 && o_enable !== 1'b1; k++) step();
		i_reset = 1;
		step();
		`CHK("mid_reset", 5'h00, {live, o_enable, o_busy})
		i_reset = 0;
		run(3'h2, 1'b0);
		complete_run();
	end
endmodule
`default_nettype wire

// file: sense_dev_model.sv
// Behavioural model of the sensing device select logic
`timescale 1ns/1ps
`default_nettype none
module sense_dev_model
(
	input wire logic i_sel0,
	input wire logic i_sel1,
	input wire logic i_sel2,
	input wire logic i_enable,
	input wire logic i_meas_mode_select,
	input wire logic i_thermal,
	output logic [2:0] o_held,
	output logic [2:0] o_sup,
	output logic o_meas_z,
	output logic o_meas_ot,
	output logic [2:0] o_meas_ch,
	output logic o_meas_current,
	output logic [3:0] o_meas_div
);
	wire logic en = (i_enable === 1'b1);
	wire logic cm = (i_meas_mode_select === 1'b1);
	wire logic [2:0] live_sel = {i_sel0 === 1'b1, i_sel1 === 1'b1, i_sel2 === 1'b1};
	always_latch
	begin
		if (!en)
			o_held = live_sel;
	end
	assign o_sup = o_held & {3{en}};
	assign o_meas_z = (o_held == 3'h0);
	assign o_meas_ot = (o_held == 3'h7) && i_thermal;
	assign o_meas_ch = (cm && en) ? o_held : live_sel;
	assign o_meas_current = cm && !o_meas_z && (o_held != 3'h7);
	assign o_meas_div = cm ? 4'ha : 4'h2;
endmodule
`default_nettype wire
